// ===== rtl/msg_port_pkg.sv
package msg_port_pkg;
    localparam logic [7:0] PTR_RESET = 8'hff;
    localparam logic [7:0] REG_STREAM = 8'hff;
    localparam logic [7:0] REG_CNT_HI = 8'hfd;
    localparam logic [7:0] REG_CNT_LO = 8'hfe;
    localparam logic [7:0] IDLE_BYTE = 8'hff;
    localparam logic [7:0] RESERVED_BYTE = 8'h00;
    localparam logic [5:0] FF_LIMIT = 6'h32;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int FIFO_DEPTH = 32;
    localparam int BYTE_W = 8;

    // Synchronised pin sample
    typedef struct packed {
        logic scl;
        logic sda;
        logic cs_n;
        logic sck;
        logic mosi;
        logic if_sel;
    } pins_t;

    localparam pins_t PINS_IDLE = '1;

    // Outbound message byte from the application
    typedef struct packed {
        logic valid;
        logic first;
        logic [7:0] data;
    } tx_beat_t;

    // Inbound byte for the message parser
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } rx_beat_t;

    typedef enum logic [2:0] {I_IDLE, I_RX, I_ACK, I_TX, I_MACK} i2c_state_t;
endpackage : msg_port_pkg

// ===== rtl/host_message_port.sv
`timescale 1ns/1ps
`default_nettype none

// Output message queue
module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    // Pointers wrap naturally, so depth must be a power of two
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : g_bad
            $error("byte_fifo: DEPTH must be a power of two of at least 2");
        end
    endgenerate

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [CW-1:0] cnt;
        logic full;
        logic empty;
    } fifo_state_t;

    fifo_state_t st;
    fifo_state_t next_st;
    logic push;
    logic pop;

    // Push, pop and flag update
    always_comb begin
        next_st = st;
        push = in_valid && !st.full;
        pop = out_ready && !st.empty;
        if (push) begin
            next_st.mem[st.wr] = in_data;
            next_st.wr = st.wr + 1'b1;
        end
        if (pop) begin
            next_st.rd = st.rd + 1'b1;
        end
        if (push && !pop) begin
            next_st.cnt = st.cnt + 1'b1;
        end else if (pop && !push) begin
            next_st.cnt = st.cnt - 1'b1;
        end
        next_st.full = (next_st.cnt == CW'(DEPTH));
        next_st.empty = (next_st.cnt == '0);
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
            st.empty <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign in_ready = !st.full;
    assign out_valid = !st.empty;
    assign out_data = st.mem[st.rd];
    assign count = st.cnt;
endmodule : byte_fifo

// Two-wire and four-wire host message port
module host_message_port #(
    parameter int DEPTH = msg_port_pkg::FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic spi_cs_n,
    input wire logic spi_sck,
    input wire logic spi_mosi,
    output logic spi_miso,
    input wire logic if_sel,
    input wire logic [7:0] dev_addr,
    input wire msg_port_pkg::tx_beat_t tx_in,
    output logic tx_ready,
    output msg_port_pkg::rx_beat_t rx_out
);
    localparam int CW = $clog2(DEPTH+1);

    generate
        if (CW > 16) begin : g_bad
            $error("host_message_port: DEPTH too large for the 16-bit count");
        end
    endgenerate

    typedef struct packed {
        msg_port_pkg::pins_t s1;
        msg_port_pkg::pins_t s2;
        msg_port_pkg::pins_t s3;
        msg_port_pkg::i2c_state_t ist;
        logic [3:0] ibit;
        logic [7:0] ish;
        logic [7:0] itx;
        logic first;
        logic rw;
        logic [1:0] wcount;
        logic [7:0] hold;
        logic [7:0] ptr;
        logic [15:0] cap;
        logic mack;
        logic sda_oe_n;
        logic [2:0] sbit;
        logic [7:0] ssh;
        logic [7:0] stx;
        logic [5:0] ffrun;
        logic miso;
        msg_port_pkg::rx_beat_t rx;
    } port_state_t;

    port_state_t st;
    port_state_t next_st;
    msg_port_pkg::pins_t pins;
    logic [7:0] head;
    logic fifo_valid;
    logic fifo_in_valid;
    logic fifo_ready;
    logic [CW-1:0] fifo_count;
    logic [15:0] count16;
    logic pop;
    logic i2c_load;
    logic spi_load;
    logic ptr_load;
    logic spi_byte;
    logic [7:0] spi_data;
    logic [7:0] rd_byte;
    logic [7:0] stream_byte;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;

    // Byte returned for a register read
    function automatic logic [7:0] reg_byte(input logic [7:0] idx, input logic have,
                                            input logic [7:0] data, input logic [15:0] cnt,
                                            input logic [15:0] cap);
        if (idx == msg_port_pkg::REG_STREAM) begin
            reg_byte = have ? data : msg_port_pkg::IDLE_BYTE;
        end else if (idx == msg_port_pkg::REG_CNT_HI) begin
            reg_byte = cnt[15:8];
        end else if (idx == msg_port_pkg::REG_CNT_LO) begin
            reg_byte = cap[7:0];
        end else begin
            reg_byte = msg_port_pkg::RESERVED_BYTE;
        end
    endfunction : reg_byte

    // A message may not open with the idle value; such a byte is swallowed
    assign fifo_in_valid = tx_in.valid &&
        !(tx_in.first && tx_in.data == msg_port_pkg::IDLE_BYTE);

    byte_fifo #(
        .WIDTH(msg_port_pkg::BYTE_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .in_data(tx_in.data),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_ready),
        .out_data(head),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .count(fifo_count)
    );

    // Pin bundle and edge detection on synchronised samples
    assign pins = '{scl: scl_i, sda: sda_i, cs_n: spi_cs_n, sck: spi_sck,
                    mosi: spi_mosi, if_sel: if_sel};
    assign count16 = 16'(fifo_count);
    assign scl_rise = st.s2.scl && !st.s3.scl;
    assign scl_fall = !st.s2.scl && st.s3.scl;
    assign start = st.s2.scl && st.s3.scl && !st.s2.sda && st.s3.sda;
    assign stop = st.s2.scl && st.s3.scl && st.s2.sda && !st.s3.sda;
    assign sck_rise = st.s2.sck && !st.s3.sck;
    assign sck_fall = !st.s2.sck && st.s3.sck;
    assign cs_fall = !st.s2.cs_n && st.s3.cs_n;
    assign rd_byte = reg_byte(st.ptr, fifo_valid, head, count16, st.cap);
    assign stream_byte = reg_byte(msg_port_pkg::REG_STREAM, fifo_valid, head, count16, st.cap);

    // Next-state logic for both ports
    always_comb begin
        next_st = st;
        i2c_load = 1'b0;
        spi_load = 1'b0;
        ptr_load = 1'b0;
        spi_byte = 1'b0;
        spi_data = {st.ssh[6:0], st.s2.mosi};
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        next_st.rx.valid = 1'b0;
        // Two-wire slave, only while select is high
        if (!st.s2.if_sel) begin
            next_st.ist = msg_port_pkg::I_IDLE;
            next_st.sda_oe_n = 1'b1;
            next_st.wcount = 2'h0;
        end else if (start || stop) begin
            if (!st.rw && st.wcount == 2'h1) begin
                next_st.ptr = st.hold;
                ptr_load = 1'b1;
            end else if (!st.rw && st.wcount == 2'h2) begin
                next_st.rx.valid = 1'b1;
                next_st.rx.data = st.hold;
            end
            next_st.wcount = 2'h0;
            next_st.rw = 1'b0;
            next_st.sda_oe_n = 1'b1;
            next_st.ibit = 4'h0;
            next_st.first = 1'b1;
            next_st.ist = start ? msg_port_pkg::I_RX : msg_port_pkg::I_IDLE;
        end else begin
            case (st.ist)
                msg_port_pkg::I_RX: begin
                    if (scl_rise) begin
                        next_st.ish = {st.ish[6:0], st.s2.sda};
                        next_st.ibit = st.ibit + 4'h1;
                    end else if (scl_fall && st.ibit == msg_port_pkg::BITS_PER_BYTE) begin
                        next_st.ibit = 4'h0;
                        if (st.first) begin
                            next_st.first = 1'b0;
                            if (st.ish[7:1] == dev_addr[7:1]) begin
                                next_st.rw = st.ish[0];
                                next_st.sda_oe_n = 1'b0;
                                next_st.ist = msg_port_pkg::I_ACK;
                            end else begin
                                next_st.ist = msg_port_pkg::I_IDLE;
                            end
                        end else begin
                            // Last byte is held back until the transfer shows its length
                            if (st.wcount != 2'h0) begin
                                next_st.rx.valid = 1'b1;
                                next_st.rx.data = st.hold;
                            end
                            next_st.hold = st.ish;
                            next_st.wcount = 2'h2 - {1'b0, (st.wcount == 2'h0)};
                            next_st.sda_oe_n = 1'b0;
                            next_st.ist = msg_port_pkg::I_ACK;
                        end
                    end
                end
                msg_port_pkg::I_ACK: begin
                    if (scl_fall && st.rw) begin
                        i2c_load = 1'b1;
                    end else if (scl_fall) begin
                        next_st.sda_oe_n = 1'b1;
                        next_st.ist = msg_port_pkg::I_RX;
                    end
                end
                msg_port_pkg::I_TX: begin
                    if (scl_fall && st.ibit == msg_port_pkg::BITS_PER_BYTE) begin
                        next_st.sda_oe_n = 1'b1;
                        next_st.ist = msg_port_pkg::I_MACK;
                    end else if (scl_fall) begin
                        next_st.itx = {st.itx[6:0], 1'b1};
                        next_st.sda_oe_n = st.itx[6];
                        next_st.ibit = st.ibit + 4'h1;
                    end
                end
                msg_port_pkg::I_MACK: begin
                    if (scl_rise) begin
                        next_st.mack = !st.s2.sda;
                    end else if (scl_fall && st.mack) begin
                        i2c_load = 1'b1;
                    end else if (scl_fall) begin
                        next_st.ist = msg_port_pkg::I_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
        // Load the next read byte from the register pointer
        if (i2c_load) begin
            next_st.itx = rd_byte;
            next_st.sda_oe_n = rd_byte[7];
            next_st.ibit = 4'h1;
            next_st.ist = msg_port_pkg::I_TX;
            if (st.ptr != msg_port_pkg::REG_STREAM) begin
                next_st.ptr = st.ptr + 8'h01;
            end
            if (st.ptr == msg_port_pkg::REG_CNT_HI) begin
                next_st.cap = count16;
            end
        end
        // Four-wire slave, mode 0, stream only
        if (st.s2.if_sel || st.s2.cs_n) begin
            next_st.sbit = 3'h0;
            next_st.miso = 1'b1;
        end else if (cs_fall) begin
            spi_load = 1'b1;
        end else if (sck_rise) begin
            next_st.ssh = spi_data;
            next_st.sbit = st.sbit + 3'h1;
            spi_byte = (st.sbit == 3'h7);
        end else if (sck_fall && st.sbit == 3'h0) begin
            spi_load = 1'b1;
        end else if (sck_fall) begin
            next_st.stx = {st.stx[6:0], 1'b1};
            next_st.miso = st.stx[6];
        end
        // Idle filter on received bytes
        if (spi_byte && spi_data != msg_port_pkg::IDLE_BYTE) begin
            next_st.rx.valid = 1'b1;
            next_st.rx.data = spi_data;
            next_st.ffrun = 6'h00;
        end else if (spi_byte && st.ffrun < msg_port_pkg::FF_LIMIT) begin
            next_st.rx.valid = 1'b1;
            next_st.rx.data = spi_data;
            next_st.ffrun = st.ffrun + 6'h01;
        end
        if (spi_load) begin
            next_st.stx = stream_byte;
            next_st.miso = stream_byte[7];
        end
        pop = fifo_valid && (spi_load || (i2c_load && st.ptr == msg_port_pkg::REG_STREAM));
    end

    // State register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
            st.s1 <= msg_port_pkg::PINS_IDLE;
            st.s2 <= msg_port_pkg::PINS_IDLE;
            st.s3 <= msg_port_pkg::PINS_IDLE;
            st.ptr <= msg_port_pkg::PTR_RESET;
            st.sda_oe_n <= 1'b1;
            st.miso <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs
    assign sda_o = 1'b0;
    assign sda_oe_n = st.sda_oe_n;
    assign spi_miso = st.miso;
    assign rx_out = st.rx;
    assign tx_ready = fifo_ready;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence addr_match_s;
        st.s2.if_sel && st.ist == msg_port_pkg::I_RX && st.first &&
        st.ibit == msg_port_pkg::BITS_PER_BYTE && scl_fall && st.ish[7:1] == dev_addr[7:1];
    endsequence

    ptr_reset_a: assert property ($fell(sys_rst) |-> st.ptr == msg_port_pkg::PTR_RESET)
        else $error("pointer not parked after reset");
    ptr_park_a: assert property (st.ptr == msg_port_pkg::REG_STREAM && !ptr_load
        |=> st.ptr == msg_port_pkg::REG_STREAM) else $error("pointer left stream register");
    ptr_step_a: assert property (i2c_load && st.ptr != msg_port_pkg::REG_STREAM
        |=> st.ptr == $past(st.ptr) + 8'h01) else $error("pointer did not step");
    stream_idle_a: assert property (i2c_load && st.ptr == msg_port_pkg::REG_STREAM
        && !fifo_valid |=> st.itx == msg_port_pkg::IDLE_BYTE && st.sda_oe_n)
        else $error("empty stream read not idle value");
    spi_idle_a: assert property (spi_load && !fifo_valid
        |=> st.miso && st.stx == msg_port_pkg::IDLE_BYTE) else $error("empty spi byte not idle");
    spi_select_a: assert property (st.s2.if_sel |-> !spi_load && !spi_byte)
        else $error("spi active while deselected");
    parse_stop_a: assert property (spi_byte && spi_data == msg_port_pkg::IDLE_BYTE
        && st.ffrun == msg_port_pkg::FF_LIMIT |=> !st.rx.valid [*2])
        else $error("idle byte passed after limit");
    parse_resume_a: assert property (spi_byte && spi_data != msg_port_pkg::IDLE_BYTE
        |=> st.rx.valid && st.rx.data == $past(spi_data) && st.ffrun == 6'h00)
        else $error("parsing not resumed");
    addr_ack_a: assert property (addr_match_s |=> !st.sda_oe_n &&
        st.ist == msg_port_pkg::I_ACK) else $error("matching address not acknowledged");
    single_index_a: assert property ((start || stop) && st.s2.if_sel && !st.rw
        && st.wcount == 2'h1 |=> st.ptr == $past(st.hold) && !st.rx.valid)
        else $error("single byte write did not load pointer");
    count_cap_a: assert property (i2c_load && st.ptr == msg_port_pkg::REG_CNT_HI
        |=> st.cap == $past(count16)) else $error("count not captured");
endmodule : host_message_port

`default_nettype wire

// ===== tb/host_master_model.sv
`timescale 1ns/1ps
`default_nettype none

// Host CPU side: two-wire master and four-wire master
module host_master_model (
    input wire logic clk,
    input wire logic sda_w,
    input wire logic miso,
    output logic scl,
    output logic sda_m,
    output logic cs_n,
    output logic sck,
    output logic mosi
);
    // Buses released, serial clock parked low
    initial begin
        scl = 1'h1;
        sda_m = 1'h1;
        cs_n = 1'h1;
        sck = 1'h0;
        mosi = 1'h0;
    end

    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask : w

    // Start (s=1) or stop (s=0): data moves while clock is high
    task automatic cond(input logic s);
        w(2);
        sda_m <= s;
        w(4);
        scl <= 1'h1;
        w(6);
        sda_m <= ~s;
        w(6);
        scl <= ~s;
    endtask : cond

    // One clock pulse; wire level taken late in the high phase
    task automatic xbit(input logic b, output logic r);
        w(2);
        sda_m <= b;
        w(6);
        scl <= 1'h1;
        w(6);
        r = sda_w;
        scl <= 1'h0;
    endtask : xbit

    // Eight bits MSB first, then the acknowledge bit
    task automatic xbyte(input logic [7:0] d, input logic a, output logic [7:0] r,
                         output logic ak);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r[i]);
        end
        xbit(a, ak);
    endtask : xbyte

    // Select or release; data in is not held once released
    task automatic spi_sel(input logic s);
        w(2);
        cs_n <= ~s;
        if (!s)
            mosi <= ~mosi;
        w(8);
    endtask : spi_sel

    // Mode 0 exchange, MSB first, both directions at once
    task automatic spi_xfer(input logic [7:0] d, output logic [7:0] r);
        for (int i = 7; i >= 0; i--) begin
            mosi <= d[i];
            w(4);
            sck <= 1'h1;
            w(4);
            r[i] = miso;
            sck <= 1'h0;
        end
    endtask : spi_xfer
endmodule : host_master_model

`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    localparam logic [6:0] ADDR = 7'h42;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic if_sel = 1'h1;
    logic [7:0] dev_addr = {ADDR, 1'h1};
    msg_port_pkg::tx_beat_t tx_in = '0;
    msg_port_pkg::rx_beat_t rx_out;
    logic sda_o, sda_oe_n, miso, tx_ready, scl, sda_m, cs_n, sck, mosi, sda_w;
    integer seed = 32'hba2e;
    int err_total = 0;
    int n_compared = 0;
    logic [7:0] exp_tx[$];
    logic [7:0] exp_rx[$];
    logic [7:0] rx_q[$];
    logic [7:0] mptr = 8'hff;
    logic [15:0] cap = '0;

    always #12.5 clk = ~clk;

    // Open-drain data wire with pull-up
    assign sda_w = sda_oe_n ? sda_m : sda_o;

    host_message_port #(.DEPTH(msg_port_pkg::FIFO_DEPTH)) dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .scl_i(scl),
        .sda_i(sda_w),
        .sda_o(sda_o),
        .sda_oe_n(sda_oe_n),
        .spi_cs_n(cs_n),
        .spi_sck(sck),
        .spi_mosi(mosi),
        .spi_miso(miso),
        .if_sel(if_sel),
        .dev_addr(dev_addr),
        .tx_in(tx_in),
        .tx_ready(tx_ready),
        .rx_out(rx_out)
    );

    host_master_model host (
        .clk(clk),
        .sda_w(sda_w),
        .miso(miso),
        .scl(scl),
        .sda_m(sda_m),
        .cs_n(cs_n),
        .sck(sck),
        .mosi(mosi)
    );

    // Parser-side capture
    always @(posedge clk)
        if (rx_out.valid === 1'h1) rx_q.push_back(rx_out.data);

    // Next stream byte, or idle filler
    function automatic logic [7:0] stream();
        if (exp_tx.size() == 0)
            return 8'hff;
        return exp_tx.pop_front();
    endfunction : stream

    // Register value at the pointer, then pointer step
    function automatic logic [7:0] reg_val();
        logic [7:0] v;
        case (mptr)
            8'hfd: begin
                cap = 16'(exp_tx.size());
                v = cap[15:8];
            end
            8'hfe: v = cap[7:0];
            8'hff: v = stream();
            default: v = 8'h00;
        endcase
        if (mptr != 8'hff)
            mptr = mptr + 8'h01;
        return v;
    endfunction : reg_val

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : close_out

    // Parser bytes against what was sent
    task automatic rx_check();
        host.w(12);
        check(16'(rx_q.size()), 16'(exp_rx.size()), "parser count");
        while (rx_q.size() > 0 && exp_rx.size() > 0)
            check({8'h0, rx_q.pop_front()}, {8'h0, exp_rx.pop_front()}, "parser byte");
        rx_q.delete();
        exp_rx.delete();
    endtask : rx_check

    task automatic addr(input logic [6:0] a, input logic rw, input logic exp_ak);
        logic [7:0] r;
        logic ak;
        host.xbyte({a, rw}, 1'h1, r, ak);
        check({15'h0, ak}, {15'h0, exp_ak}, "address ack");
    endtask : addr

    // Read n bytes, with or without an index phase
    task automatic rd(input logic idx_en, input logic [7:0] idx, input int n);
        logic [7:0] r;
        logic ak;
        host.cond(1'h1);
        if (idx_en) begin
            addr(dev_addr[7:1], 1'h0, 1'h0);
            host.xbyte(idx, 1'h1, r, ak);
            check({15'h0, ak}, 16'h0, "index ack");
            mptr = idx;
            host.cond(1'h1);
        end
        addr(dev_addr[7:1], 1'h1, 1'h0);
        for (int i = 0; i < n; i++) begin
            host.xbyte(8'hff, 1'(i == n - 1), r, ak);
            check({8'h0, r}, {8'h0, reg_val()}, "read byte");
        end
        host.cond(1'h0);
    endtask : rd

    // Write n bytes, first one given
    task automatic wr(input int n, input logic [7:0] b0);
        logic [7:0] r;
        logic [7:0] d;
        logic ak;
        host.cond(1'h1);
        addr(dev_addr[7:1], 1'h0, 1'h0);
        for (int i = 0; i < n; i++) begin
            d = (i == 0) ? b0 : 8'($random(seed));
            if (n == 1)
                mptr = d;
            else
                exp_rx.push_back(d);
            host.xbyte(d, 1'h1, r, ak);
            check({15'h0, ak}, 16'h0, "data ack");
        end
        host.cond(1'h0);
        rx_check();
    endtask : wr

    // Offer one outbound byte
    task automatic beat(input logic f, input logic [7:0] d, output logic took);
        tx_in <= '{valid: 1'h1, first: f, data: d};
        @(posedge clk);
        took = tx_ready;
        if (took === 1'h1 && !(f && d == 8'hff))
            exp_tx.push_back(d);
    endtask : beat

    // Main sequence
    initial begin
        logic took;
        logic [7:0] r;
        logic [7:0] d;
        int k;
        int queued;
        repeat (2) @(posedge clk);
        sys_rst <= 1'h0;
        repeat (2) @(posedge clk);
        check({13'h0, sda_oe_n, miso, tx_ready}, 16'h0007, "reset outputs");
        rd(1'h0, 8'h00, 2);
        host.cond(1'h1);
        addr(ADDR ^ 7'h01, 1'h0, 1'h1);
        host.cond(1'h0);
        beat(1'h1, 8'hff, took);
        for (int i = 0; i < 5; i++) begin
            d = 8'($random(seed));
            beat(1'(i == 0), (i == 0 && d == 8'hff) ? 8'h5a : d, took);
        end
        tx_in <= '0;
        @(posedge clk);
        d = 8'($random(seed)) % 8'hfd;
        rd(1'h1, d, 2);
        wr(1, 8'hfd);
        rd(1'h0, 8'h00, 2);
        rd(1'h0, 8'h00, 3);
        rd(1'h0, 8'h00, 3);
        wr(4, 8'h3c);
        rd(1'h0, 8'h00, 1);
        // Move the own address; the old one must go unanswered
        dev_addr <= {ADDR ^ 7'h15, 1'h0};
        @(posedge clk);
        host.cond(1'h1);
        addr(ADDR, 1'h1, 1'h1);
        host.cond(1'h0);
        rd(1'h0, 8'h00, 1);
        k = 0;
        for (int i = 0; i < 40; i++) begin
            beat(1'h0, 8'($random(seed)), took);
            if (took === 1'h1)
                k++;
        end
        tx_in <= '0;
        @(posedge clk);
        check(16'(k), 16'(msg_port_pkg::FIFO_DEPTH), "queue depth");
        host.spi_sel(1'h1);
        host.spi_xfer(8'h3c, r);
        host.spi_sel(1'h0);
        check({8'h0, r}, 16'h00ff, "port off");
        rx_check();
        if_sel <= 1'h0;
        host.cond(1'h1);
        addr(dev_addr[7:1], 1'h0, 1'h1);
        host.cond(1'h0);
        host.spi_sel(1'h1);
        // Host parser keeps message bytes and drops idle filler
        queued = exp_tx.size();
        k = 0;
        for (int i = 0; i < 60; i++) begin
            d = (i < 55) ? 8'hff : (8'($random(seed)) & 8'h7f);
            if (i < 50 || i >= 55)
                exp_rx.push_back(d);
            host.spi_xfer(d, r);
            if (r !== 8'hff || exp_tx.size() != 0)
                k++;
            check({8'h0, r}, {8'h0, stream()}, "four-wire out");
        end
        host.spi_sel(1'h0);
        check(16'(k), 16'(queued), "host kept");
        rx_check();
        close_out();
    end

    // Cut a hung run short
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        close_out();
    end
endmodule : testbench

`default_nettype wire
